// [rtl/ecc_pkg.sv]
// Shared constants and carrier types for the protected memory and its link-mode state
package ecc_pkg;
  localparam int ADDR_W      = 8;
  localparam int WORD_W      = 32;
  localparam int CHK_W       = 6;
  localparam int WORDS       = 64;
  localparam int WIDX_W      = 6;
  localparam int BYTES       = 4;
  localparam int SYN_W       = 6;
  localparam int BITS        = 8;
  localparam logic [15:0] STATUS_DEFAULT = 16'h0000;
  localparam int LINK_PROTOCOL_FIELD_HI     = 12;
  localparam int LINK_PROTOCOL_FIELD_LO     = 11;
  localparam logic [7:0] IO_RESET_CODE = 8'hFF;
  localparam logic [3:0] IO_ALL_HIGH   = 4'hF;
  localparam logic [3:0] IO_CLOCKS     = 4'h8;
  localparam logic [1:0] LINK_PROTOCOL_FIELD_SPI      = 2'h0;

  typedef enum logic [1:0] {
    MODE_SPI  = 2'b00,
    MODE_DUAL = 2'b01,
    MODE_QUAD = 2'b10
  } link_mode_e;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
  } mem_req_s;

  typedef struct packed {
    logic        valid;
    logic [7:0]  rdata;
  } mem_rsp_s;
endpackage

// [rtl/ecc_sram.sv]
// Check-bit protected byte memory with link-mode and status power-up state
`timescale 1ns/1ps

// How it works
// RL1: Six check bits per aligned 32-bit word.
// RL2: Any byte write recomputes word check bits.
// RL3: Byte read rechecks whole containing word.
// RL4: Syndrome locates bad bit; invert it.
// RL5: Only single-bit errors get corrected.
// RL6: Check bits never reach host ports.
// RL7: Idle until chip select falls low.
// RL8: Normal power-up: SPI, default status.
// RL9: Backup power keeps status and mode.
// RL10: Eight clocks, all lines high resets.
// RL11: Host sends reset command after reboot.
// RL12: Host may continue after SPI return.
// RL13: All-ones command; SPI, protocol bits cleared.
// RL14: Uncorrectable error: data passed unmodified; a syndrome naming a data bit still inverts that bit.
module ecc_sram
(
  input  wire logic              CLK,
  input  wire logic              RST_N,
  input  wire logic              BACKUP_HELD,
  input  wire logic              CS_N,
  input  wire logic              LINK_CLK_EDGE,
  input  wire logic [3:0]        LINE_IN,
  input  wire ecc_pkg::mem_req_s REQ,
  input  wire logic [15:0]       STATUS_WDATA,
  input  wire logic              STATUS_WR,
  input  wire logic [31:0]       ERR_INJECT,
  output      ecc_pkg::mem_rsp_s RSP,
  output      logic              ACTIVE,
  output      logic [1:0]        LINK_MODE,
  output      logic [15:0]       STATUS
);
  // Check-bit j covers data bits whose code position has bit j set
  function automatic logic [ecc_pkg::CHK_W-1:0] check_of(input logic [ecc_pkg::WORD_W-1:0] d);
    logic [ecc_pkg::CHK_W-1:0] c;
    logic [ecc_pkg::SYN_W-1:0] p;
    c = '0;
    for (int i = 0; i < ecc_pkg::WORD_W; i++)
    begin
      p = pos_of(i);
      for (int j = 0; j < ecc_pkg::CHK_W; j++)
      begin
        if (p[j])
        begin
          c[j] = c[j] ^ d[i];
        end
      end
    end
    return c;
  endfunction

  // Non-power-of-two positions 3..38 so a single-bit syndrome is unique
  function automatic logic [ecc_pkg::SYN_W-1:0] pos_of(input int i);
    int p;
    int k;
    p = 0;
    k = -1;
    for (int n = 3; n < 64; n++)
    begin
      if ((n & (n - 1)) != 0 && k < i)
      begin
        k = k + 1;
        p = n;
      end
    end
    return p[ecc_pkg::SYN_W-1:0];
  endfunction

  logic [ecc_pkg::WORD_W-1:0] data_mem [ecc_pkg::WORDS];
  logic [ecc_pkg::CHK_W-1:0]  chk_mem  [ecc_pkg::WORDS];

  logic [ecc_pkg::WIDX_W-1:0] widx;
  logic [1:0]                 bsel;
  logic [ecc_pkg::WORD_W-1:0] cur_word;
  logic [ecc_pkg::WORD_W-1:0] merged;
  logic [ecc_pkg::SYN_W-1:0]  syndrome;
  logic [ecc_pkg::WORD_W-1:0] flip;
  logic [ecc_pkg::WORD_W-1:0] fixed;

  assign widx     = REQ.addr[ecc_pkg::ADDR_W-1:2];
  assign bsel     = REQ.addr[1:0];
  assign cur_word = data_mem[widx];

  always_comb
  begin
    // Merge into the corrected word so a latent bit error is not sealed in
    merged = fixed;
    merged[bsel*ecc_pkg::BITS +: ecc_pkg::BITS] = REQ.wdata;
  end

  // Compare the stored check with one recomputed over the whole word
  assign syndrome = check_of(cur_word) ^ chk_mem[widx]; // see RL3

  // Unknown syndromes leave flip zero, data goes out as stored
  generate
    for (genvar g = 0; g < ecc_pkg::WORD_W; g++)
    begin : g_flip
      assign flip[g] = (syndrome == pos_of(g)); // see RL4 see RL5 see RL14
    end
  endgenerate
  assign fixed = cur_word ^ flip;

  // Only the selected corrected byte is presented
  ecc_pkg::mem_rsp_s next_rsp;
  always_comb
  begin
    next_rsp.valid = REQ.rd && !REQ.wr && !CS_N;
    next_rsp.rdata = fixed[bsel*ecc_pkg::BITS +: ecc_pkg::BITS]; // see RL6
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      RSP <= '0;
    end
    else
    begin
      RSP <= next_rsp;
    end
  end

  // Array contents have no reset; backup supply holds them
  always_ff @(posedge CLK)
  begin
    if (REQ.wr && !CS_N)
    begin
      // Test hook: set bits are stored inverted behind clean check bits
      data_mem[widx] <= merged ^ ERR_INJECT;
      chk_mem[widx]  <= check_of(merged); // see RL1 see RL2
    end
  end

  // Link-mode and status state
  logic [3:0]  clk_cnt;
  logic [3:0]  next_clk_cnt;
  logic        all_high;
  logic        next_all_high;
  logic        cs_q;
  logic        next_active;
  logic [1:0]  next_mode;
  logic [15:0] next_status;
  logic        reset_cmd;

  assign reset_cmd = (clk_cnt == ecc_pkg::IO_CLOCKS) && all_high && (CS_N && !cs_q);

  always_comb
  begin
    next_clk_cnt  = clk_cnt;
    next_all_high = all_high;
    next_active   = ACTIVE;
    next_mode     = LINK_MODE;
    next_status   = STATUS;
    if (cs_q && !CS_N)
    begin
      next_active   = 1'b1; // see RL7
      next_clk_cnt  = '0;
      next_all_high = 1'b1;
    end
    else if (!CS_N && LINK_CLK_EDGE)
    begin
      // Extra clocks after the eighth are ignored
      if (clk_cnt < ecc_pkg::IO_CLOCKS)
      begin
        next_clk_cnt  = clk_cnt + 4'h1;
        next_all_high = all_high && (LINE_IN == ecc_pkg::IO_ALL_HIGH); // see RL10
      end
    end
    if (CS_N && !cs_q)
    begin
      next_active = 1'b0;
    end
    if (STATUS_WR && !CS_N)
    begin
      next_status = STATUS_WDATA;
      next_mode   = STATUS_WDATA[ecc_pkg::LINK_PROTOCOL_FIELD_HI:ecc_pkg::LINK_PROTOCOL_FIELD_LO];
    end
    if (reset_cmd)
    begin
      next_mode = ecc_pkg::MODE_SPI; // see RL13
      next_status[ecc_pkg::LINK_PROTOCOL_FIELD_HI:ecc_pkg::LINK_PROTOCOL_FIELD_LO] = ecc_pkg::LINK_PROTOCOL_FIELD_SPI;
    end
  end

  // Reset models power-up; backup keeps prior mode and status
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      clk_cnt  <= '0;
      all_high <= 1'b0;
      cs_q     <= 1'b1;
      ACTIVE   <= 1'b0; // see RL7
    end
    else
    begin
      clk_cnt  <= next_clk_cnt;
      all_high <= next_all_high;
      cs_q     <= CS_N;
      ACTIVE   <= next_active;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N && !BACKUP_HELD)
    begin
      LINK_MODE <= ecc_pkg::MODE_SPI; // see RL8
      STATUS    <= ecc_pkg::STATUS_DEFAULT;
    end
    else if (RST_N)
    begin
      LINK_MODE <= next_mode; // see RL9
      STATUS    <= next_status;
    end
  end

  mode_reset_a: assert property (@(posedge CLK) disable iff (!RST_N) // see RL13
    reset_cmd |=> (LINK_MODE == ecc_pkg::MODE_SPI) && (STATUS[ecc_pkg::LINK_PROTOCOL_FIELD_HI:ecc_pkg::LINK_PROTOCOL_FIELD_LO] == ecc_pkg::LINK_PROTOCOL_FIELD_SPI))
    else $error("reset command did not return link to SPI");
  idle_after_rise_a: assert property (@(posedge CLK) disable iff (!RST_N) // see RL7
    (CS_N && !cs_q) |=> !ACTIVE)
    else $error("device active after chip select rose");
  wake_on_fall_a: assert property (@(posedge CLK) disable iff (!RST_N) // see RL7
    (cs_q && !CS_N) |=> ACTIVE)
    else $error("device not active after chip select fell");
  read_return_a: assert property (@(posedge CLK) disable iff (!RST_N) // see RL3
    (REQ.rd && !REQ.wr && !CS_N) |=> RSP.valid)
    else $error("read produced no answer");
  single_flip_a: assert property (@(posedge CLK) disable iff (!RST_N) // see RL5
    $countones(flip) <= 1)
    else $error("more than one bit inverted");
  clean_pass_a: assert property (@(posedge CLK) disable iff (!RST_N) // see RL14
    (syndrome == '0) |-> (fixed == cur_word))
    else $error("clean word altered");
  locate_bit_a: assert property (@(posedge CLK) disable iff (!RST_N) // see RL4
    (flip != '0) |-> (check_of(fixed) == chk_mem[widx]))
    else $error("correction did not match stored check");
  count_cap_a: assert property (@(posedge CLK) disable iff (!RST_N) // see RL10
    clk_cnt <= ecc_pkg::IO_CLOCKS)
    else $error("link clock count overran");
endmodule // ecc_sram

// [verification/host_link_model.sv]
// Host-side link model that sends the io-mode reset frame whenever the bench raises go
`timescale 1ns/1ps
module host_link_model
(
  input  wire logic       clk,
  input  wire logic       go,
  output      logic       cs_n,
  output      logic       edge_pulse,
  output      logic [3:0] lines,
  output      logic       busy
);
  initial
  begin
    cs_n = 1'b1;
    edge_pulse = 1'b0;
    lines = 4'h5;
    busy = 1'b0;
  end

  // Frame is sent before any other traffic once the bench asks
  always
  begin
    @(posedge clk iff go);
    #1 busy = 1'b1;
    cs_n = 1'b0;
    repeat (8)
    begin
      @(posedge clk) #1 edge_pulse = 1'b1;
      lines = 4'hF;
      @(posedge clk) #1 edge_pulse = 1'b0;
      // Lines undriven between edges, so show the inverse level
      lines = ~lines;
    end
    @(posedge clk) #1 cs_n = 1'b1;
    busy = 1'b0;
  end
endmodule // host_link_model

// [verification/ecc_sram_tb.sv]
// Self-checking bench for the protected memory and its power-up link state
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module ecc_sram_tb;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              backup = 1'b0;
  logic              tb_cs_n = 1'b1;
  logic              go = 1'b0;
  logic              host_cs_n;
  logic              edge_pulse;
  logic [3:0]        lines;
  logic              busy;
  ecc_pkg::mem_req_s req = '0;
  logic [15:0]       status_wdata = 16'h0000;
  logic [31:0]       inject = 32'h0000_0000;
  logic              status_wr = 1'b0;
  ecc_pkg::mem_rsp_s rsp;
  logic              active;
  logic [1:0]        link_mode;
  logic [15:0]       status;
  int                error_cnt = 0;
  int                checks_done = 0;

  always #5 clk = ~clk;

  host_link_model host (.clk(clk), .go(go), .cs_n(host_cs_n), .edge_pulse(edge_pulse), .lines(lines), .busy(busy));
  ecc_sram uut (.CLK(clk), .RST_N(rst_n), .BACKUP_HELD(backup), .CS_N(host_cs_n & tb_cs_n),
    .LINK_CLK_EDGE(edge_pulse), .LINE_IN(lines), .REQ(req), .STATUS_WDATA(status_wdata),
    .STATUS_WR(status_wr), .ERR_INJECT(inject), .RSP(rsp), .ACTIVE(active), .LINK_MODE(link_mode),
    .STATUS(status));

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
    int i;
    req = '{wr: w, rd: !w, addr: a, wdata: d};
    step(1);
    req = '0;
    if (!w)
    begin
      // Registered answer, allow a short bounded wait
      for (i = 0; i < 2 && rsp.valid !== 1'b1; i++)
        step(1);
      `CHK(rsp.valid, 1'b1)
      `CHK(rsp.rdata, exp)
    end
    step(1);
  endtask

  task automatic set_status(input logic [15:0] v);
    // Status writes are only taken while selected
    status_wdata = v;
    status_wr = 1'b1;
    tb_cs_n = 1'b0;
    step(1);
    status_wr = 1'b0;
    tb_cs_n = 1'b1;
    step(1);
  endtask

  task automatic power_up(input logic keep);
    backup = keep;
    rst_n = 1'b0;
    step(8);
    rst_n = 1'b1;
    step(1);
  endtask

  task automatic t_powerup;
    `CHK(link_mode, ecc_pkg::LINK_PROTOCOL_FIELD_SPI)
    `CHK(status, ecc_pkg::STATUS_DEFAULT)
    `CHK(active, 1'b0)
    $display("test powerup done");
  endtask

  task automatic t_data;
    int i;
    tb_cs_n = 1'b0;
    for (i = 0; i < 4; i++)
      access(1'b1, 8'(8'h14 + i), 8'(8'hA0 + i), 8'h00);
    `CHK(active, 1'b1)
    // Single byte rewrite must leave its neighbours intact
    access(1'b1, 8'h16, 8'h5C, 8'h00);
    access(1'b0, 8'h14, 8'h00, 8'hA0);
    access(1'b0, 8'h15, 8'h00, 8'hA1);
    access(1'b0, 8'h16, 8'h00, 8'h5C);
    access(1'b0, 8'h17, 8'h00, 8'hA3);
    tb_cs_n = 1'b1;
    req = '{wr: 1'b0, rd: 1'b1, addr: 8'h14, wdata: 8'h00};
    step(1);
    `CHK(rsp.valid, 1'b0)
    step(1);
    `CHK(rsp.valid, 1'b0)
    `CHK(active, 1'b0)
    req = '0;
    $display("test data done");
  endtask

  task automatic t_ecc;
    tb_cs_n = 1'b0;
    step(1);
    // One stored bit inverted behind clean check bits
    inject = 32'h0000_0200;
    access(1'b1, 8'h14, 8'hA0, 8'h00);
    inject = 32'h0000_0000;
    access(1'b0, 8'h15, 8'h00, 8'hA1);
    access(1'b0, 8'h14, 8'h00, 8'hA0);
    // Two inverted bits whose syndrome names no data bit
    inject = 32'h8000_0010;
    access(1'b1, 8'h14, 8'hA0, 8'h00);
    inject = 32'h0000_0000;
    access(1'b0, 8'h14, 8'h00, 8'hB0);
    access(1'b0, 8'h17, 8'h00, 8'h23);
    tb_cs_n = 1'b1;
    step(2);
    $display("test ecc done");
  endtask

  task automatic t_io_reset;
    int i;
    set_status(16'h15AA);
    `CHK(link_mode, ecc_pkg::MODE_QUAD)
    go = 1'b1;
    step(2);
    go = 1'b0;
    `CHK(active, 1'b1)
    for (i = 0; i < 40 && busy; i++)
      step(1);
    `CHK(busy, 1'b0)
    step(2);
    `CHK(link_mode, ecc_pkg::LINK_PROTOCOL_FIELD_SPI)
    `CHK(status, 16'h05AA)
    // Back in single-line mode the host may pick another mode
    set_status(16'h0800);
    `CHK(link_mode, ecc_pkg::MODE_DUAL)
    $display("test io reset done");
  endtask

  task automatic t_backup;
    set_status(16'h0955);
    power_up(1'b1);
    `CHK(status, 16'h0955)
    `CHK(link_mode, ecc_pkg::MODE_DUAL)
    power_up(1'b0);
    `CHK(status, ecc_pkg::STATUS_DEFAULT)
    `CHK(link_mode, ecc_pkg::LINK_PROTOCOL_FIELD_SPI)
    $display("test backup done");
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    power_up(1'b0);
    t_powerup();
    t_data();
    t_ecc();
    t_io_reset();
    t_backup();
    close_out();
  end

  // Whole run needs well under a thousand cycles
  initial
  begin
    #200000;
    error_cnt++;
    close_out();
  end
endmodule // ecc_sram_tb
